// [design/crt_defines.vh]
// Constants for the clock, reset and reload timer block
`ifndef CRT_DEFINES_VH
`define CRT_DEFINES_VH
// Clock rate and reset stretch
`define CRT_CLK_KHZ         20000
`define CRT_RST_HOLD_MS     10
// Oscillator ratings in hertz
`define CRT_HF_OSC_HZ       14320000
`define CRT_LF_OSC_HZ       32768
// Register offsets
`define CRT_ADDR_MASK       8'he7
`define CRT_ADDR_CLK_CTRL   8'he8
`define CRT_ADDR_WAIT       8'he9
`define CRT_ADDR_T1_RELOAD  8'hea
`define CRT_ADDR_T1_COUNT   8'heb
`define CRT_ADDR_T2_RELOAD  8'hec
`define CRT_ADDR_T2_COUNT   8'hed
`define CRT_ADDR_IRQ        8'hfe
// Clock control fields
`define CRT_CC_HF_EN        0
`define CRT_CC_LF_EN        1
`define CRT_CC_SEL          2
`define CRT_CC_DIV_LO       3
`define CRT_CC_DIV_HI       4
`define CRT_CC_RESET        5'h01
// Interrupt request bits
`define CRT_IRQ_T1          0
`define CRT_IRQ_T2          1
// Widths and reset values
`define CRT_TMR_W           8
`define CRT_WS_W            3
`define CRT_TMR_TOP         8'hff
`define CRT_BYTE_ZERO       8'h00
`define CRT_WS_RESET        3'h0
`define CRT_MEM_CNT_ONE     4'h1
`endif

// [design/crt_sync.v]
// Two flip-flop synchroniser
`timescale 1ns/1ps
module crt_sync (
  // Clock and reset
  input  wire clk,
  input  wire srst,
  // Asynchronous level in, synchronised level out
  input  wire din,
  output reg  dout
);
  reg meta_reg;

  always @(posedge clk) begin
    if (srst) begin
      meta_reg <= 1'b1;
      dout     <= 1'b1;
    end else begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end
endmodule

// [design/crt_timer.v]
// Eight-bit auto-reload up-counter with overflow pulse
`timescale 1ns/1ps
`include "crt_defines.vh"
module crt_timer (
  // Clock and reset
  input  wire                   clk,
  input  wire                   srst,
  // Count tick and reload value
  input  wire                   tick,
  input  wire [`CRT_TMR_W-1:0]  reload,
  input  wire                   load_req,
  // Counter state and overflow
  output reg  [`CRT_TMR_W-1:0]  count,
  output reg                    ovf
);
  always @(posedge clk) begin
    if (srst) begin
      count <= `CRT_BYTE_ZERO;
      ovf   <= 1'b0;
    end else begin
      ovf <= tick && (count == `CRT_TMR_TOP);
      if (load_req) begin
        count <= reload;
      end else if (tick && (count == `CRT_TMR_TOP)) begin
        count <= reload;
      end else if (tick) begin
        count <= count + 8'h01;
      end
    end
  end
endmodule

// [design/crt_top.v]
// Clock, reset and reload timer unit
`timescale 1ns/1ps
`include "crt_defines.vh"
module crt_top #(
  parameter RST_HOLD_CYCLES = `CRT_RST_HOLD_MS * `CRT_CLK_KHZ
) (
  // Clock and reset
  input  wire       clk,
  input  wire       srst,
  // Reset pin
  input  wire       reset_pin_n,
  output reg        core_rst_out,
  // Oscillator pins
  input  wire       hf_osc_in,
  input  wire       lf_osc_in,
  output wire       hf_osc_en,
  output wire       lf_osc_en,
  output reg        hf_clk_out,
  output reg        lf_clk_out,
  // Processor clock
  output reg        cpu_clk_out,
  output reg        cpu_tick,
  // Memory access stretch
  input  wire       mem_req,
  input  wire       mem_reg_ram,
  output wire       mem_busy,
  output reg        mem_done,
  // Register port
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  // Interrupt
  input  wire       global_irq_en,
  output reg        irq_out
);
  localparam integer HOLD_W = 32;
  // Divisor mask for two-bit field
  function [2:0] div_mask;
    input [1:0] sel;
    begin
      case (sel)
        2'h0:    div_mask = 3'h0;
        2'h1:    div_mask = 3'h1;
        2'h2:    div_mask = 3'h3;
        default: div_mask = 3'h7;
      endcase
    end
  endfunction

  // Synchronised pins
  wire       rst_pin_s;
  wire       hf_s;
  wire       lf_s;
  wire       dev_rst;

  // Reset stretch state
  reg  [HOLD_W-1:0] hold_reg;
  reg  [HOLD_W-1:0] hold_next;
  reg               wake_reg;

  // Registers
  reg  [4:0] clk_ctrl_reg;
  reg  [2:0] wait_reg;
  reg  [7:0] t1_reload_reg;
  reg  [7:0] t2_reload_reg;
  reg  [1:0] interrupt_mask_reg;
  reg  [1:0] irq_reg;
  reg  [1:0] irq_next;

  // Oscillator edges
  reg        hf_prev_reg;
  reg        lf_prev_reg;
  wire       hf_gated;
  wire       lf_gated;
  wire       hf_rise;
  wire       lf_rise;

  // Processor clock divider and access counter
  reg  [2:0] div_cnt_reg;
  wire       src_level;
  wire       src_rise;
  wire [2:0] mask;
  reg  [3:0] mem_cnt_reg;

  // Timer outputs
  wire [7:0] t1_count;
  wire [7:0] t2_count;
  wire       t1_ovf;
  wire       t2_ovf;

  // Bus decodes
  wire wr_cc;
  wire wr_t1c;
  wire wr_t2c;
  wire wr_irq;

  crt_sync u_sync_rst (
    .clk  (clk),
    .srst (srst),
    .din  (reset_pin_n),
    .dout (rst_pin_s)
  );

  crt_sync u_sync_hf (
    .clk  (clk),
    .srst (srst),
    .din  (hf_osc_in),
    .dout (hf_s)
  );

  crt_sync u_sync_lf (
    .clk  (clk),
    .srst (srst),
    .din  (lf_osc_in),
    .dout (lf_s)
  );

  // Reset while pin low or bus reset
  assign dev_rst = srst | ~rst_pin_s;

  always @* begin
    hold_next = hold_reg;
    if (!wake_reg) begin
      hold_next = hold_reg + 32'h1;
    end
  end

  always @(posedge clk) begin
    if (dev_rst) begin
      hold_reg     <= 32'h0;
      wake_reg     <= 1'b0;
      core_rst_out <= 1'b1;
    end else begin
      hold_reg <= hold_next;
      if (hold_next >= RST_HOLD_CYCLES) begin
        wake_reg     <= 1'b1;
        core_rst_out <= 1'b0;
      end
    end
  end

  // Bus write decodes
  assign wr_cc  = reg_wr && (reg_addr == `CRT_ADDR_CLK_CTRL);
  assign wr_t1c = reg_wr && (reg_addr == `CRT_ADDR_T1_COUNT);
  assign wr_t2c = reg_wr && (reg_addr == `CRT_ADDR_T2_COUNT);
  assign wr_irq = reg_wr && (reg_addr == `CRT_ADDR_IRQ);

  assign hf_osc_en = clk_ctrl_reg[`CRT_CC_HF_EN];
  assign lf_osc_en = clk_ctrl_reg[`CRT_CC_LF_EN];

  assign hf_gated = hf_osc_en ? hf_s : 1'b1;
  assign lf_gated = lf_osc_en ? lf_s : 1'b1;
  assign hf_rise  = hf_gated & ~hf_prev_reg;
  assign lf_rise  = lf_gated & ~lf_prev_reg;

  // source select, fast gated by wake
  assign src_level = clk_ctrl_reg[`CRT_CC_SEL] ? lf_gated : (hf_gated & wake_reg);
  assign src_rise  = clk_ctrl_reg[`CRT_CC_SEL] ? lf_rise : (hf_rise & wake_reg);

  assign mask = div_mask(clk_ctrl_reg[`CRT_CC_DIV_HI:`CRT_CC_DIV_LO]);

  // Register writes
  always @(posedge clk) begin
    if (dev_rst) begin
      clk_ctrl_reg       <= `CRT_CC_RESET;
      wait_reg           <= `CRT_WS_RESET;
      t1_reload_reg      <= `CRT_BYTE_ZERO;
      t2_reload_reg      <= `CRT_BYTE_ZERO;
      interrupt_mask_reg <= 2'h0;
    end else if (reg_wr) begin
      case (reg_addr)
        `CRT_ADDR_CLK_CTRL: begin
          clk_ctrl_reg <= reg_wdata[4:0];
        end
        `CRT_ADDR_WAIT: begin
          wait_reg <= reg_wdata[2:0];
        end
        `CRT_ADDR_T1_RELOAD: begin
          t1_reload_reg <= reg_wdata;
        end
        `CRT_ADDR_T2_RELOAD: begin
          t2_reload_reg <= reg_wdata;
        end
        `CRT_ADDR_MASK: begin
          interrupt_mask_reg <= reg_wdata[1:0];
        end
        default: begin
          clk_ctrl_reg <= clk_ctrl_reg;
        end
      endcase
    end
  end

  // Edge history and processor clock
  always @(posedge clk) begin
    if (dev_rst) begin
      hf_prev_reg <= 1'b1;
      lf_prev_reg <= 1'b1;
      div_cnt_reg <= 3'h0;
      cpu_clk_out <= 1'b1;
      cpu_tick    <= 1'b0;
      hf_clk_out  <= 1'b1;
      lf_clk_out  <= 1'b1;
    end else begin
      hf_prev_reg <= hf_gated;
      lf_prev_reg <= lf_gated;
      hf_clk_out  <= hf_gated;
      lf_clk_out  <= lf_gated;
      if (src_rise) begin
        div_cnt_reg <= (div_cnt_reg + 3'h1) & mask;
      end
      cpu_tick <= src_rise && ((div_cnt_reg & mask) == mask);
      if (mask == 3'h0) begin
        cpu_clk_out <= src_level;
      end else if (src_rise && ((div_cnt_reg & mask) == mask)) begin
        cpu_clk_out <= 1'b1;
      end else if (src_rise && ((div_cnt_reg & mask) == (mask >> 1))) begin
        cpu_clk_out <= 1'b0;
      end
    end
  end

  assign mem_busy = (mem_cnt_reg != 4'h0);

  always @(posedge clk) begin
    if (dev_rst) begin
      mem_cnt_reg <= 4'h0;
      mem_done    <= 1'b0;
    end else begin
      mem_done <= 1'b0;
      if (!mem_busy && mem_req) begin
        if (mem_reg_ram) begin
          mem_cnt_reg <= `CRT_MEM_CNT_ONE;
        end else begin
          mem_cnt_reg <= `CRT_MEM_CNT_ONE + {1'b0, wait_reg};
        end
      end else if (mem_busy && cpu_tick) begin
        mem_cnt_reg <= mem_cnt_reg - 4'h1;
        if (mem_cnt_reg == `CRT_MEM_CNT_ONE) begin
          mem_done <= 1'b1;
        end
      end
    end
  end

  crt_timer u_t1 (
    .clk      (clk),
    .srst     (dev_rst),
    .tick     (hf_rise),
    .reload   (t1_reload_reg),
    .load_req (wr_t1c),
    .count    (t1_count),
    .ovf      (t1_ovf)
  );

  crt_timer u_t2 (
    .clk      (clk),
    .srst     (dev_rst),
    .tick     (lf_rise),
    .reload   (t2_reload_reg),
    .load_req (wr_t2c),
    .count    (t2_count),
    .ovf      (t2_ovf)
  );

  always @* begin
    irq_next = irq_reg;
    if (wr_irq) begin
      irq_next = irq_reg & reg_wdata[1:0];
    end
    irq_next[`CRT_IRQ_T1] = irq_next[`CRT_IRQ_T1] | t1_ovf;
    irq_next[`CRT_IRQ_T2] = irq_next[`CRT_IRQ_T2] | t2_ovf;
  end

  always @(posedge clk) begin
    if (dev_rst) begin
      irq_reg <= 2'h0;
      irq_out <= 1'b0;
    end else begin
      irq_reg <= irq_next;
      irq_out <= global_irq_en && ((irq_reg & interrupt_mask_reg) != 2'h0);
    end
  end

  // Read data, one cycle after strobe
  always @(posedge clk) begin
    if (dev_rst) begin
      reg_rdata <= `CRT_BYTE_ZERO;
    end else if (reg_rd) begin
      case (reg_addr)
        `CRT_ADDR_CLK_CTRL: begin
          reg_rdata <= {3'h0, clk_ctrl_reg};
        end
        `CRT_ADDR_WAIT: begin
          reg_rdata <= {5'h00, wait_reg};
        end
        `CRT_ADDR_T1_RELOAD: begin
          reg_rdata <= t1_reload_reg;
        end
        `CRT_ADDR_T1_COUNT: begin
          reg_rdata <= t1_count;
        end
        `CRT_ADDR_T2_RELOAD: begin
          reg_rdata <= t2_reload_reg;
        end
        `CRT_ADDR_T2_COUNT: begin
          reg_rdata <= t2_count;
        end
        `CRT_ADDR_MASK: begin
          reg_rdata <= {6'h00, interrupt_mask_reg};
        end
        `CRT_ADDR_IRQ: begin
          reg_rdata <= {6'h00, irq_reg};
        end
        default: begin
          reg_rdata <= `CRT_BYTE_ZERO;
        end
      endcase
    end else begin
      reg_rdata <= `CRT_BYTE_ZERO;
    end
  end
endmodule

// [bench/crt_chk.sv]
// Assertion checker for the clock, reset and timer unit
`timescale 1ns/1ps
module crt_chk #(
  parameter RST_HOLD_CYCLES = 20
) (
  // Clock and reset
  input wire       clk,
  input wire       srst,
  // Reset and oscillators
  input wire       reset_pin_n,
  input wire       core_rst_out,
  input wire       hf_osc_in,
  input wire       lf_osc_in,
  input wire       hf_osc_en,
  input wire       lf_osc_en,
  input wire       hf_clk_out,
  input wire       lf_clk_out,
  // Processor clock and memory stretch
  input wire       cpu_clk_out,
  input wire       cpu_tick,
  input wire       mem_req,
  input wire       mem_reg_ram,
  input wire       mem_busy,
  input wire       mem_done,
  // Register port and interrupt
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  input wire       global_irq_en,
  input wire       irq_out
);
  // Cycles since both reset sources were released
  reg [15:0] rel_cnt_reg;
  always @(posedge clk) begin
    if (srst || !reset_pin_n)
      rel_cnt_reg <= 16'h0000;
    else if (rel_cnt_reg != 16'hffff)
      rel_cnt_reg <= rel_cnt_reg + 16'h0001;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  rst_hold_a: assert property ((rel_cnt_reg != 16'h0000 && rel_cnt_reg < RST_HOLD_CYCLES) |-> core_rst_out)
    else $error("core reset ended early");
  rst_end_a: assert property ((rel_cnt_reg > RST_HOLD_CYCLES + 4) |-> !core_rst_out)
    else $error("core reset held too long");
  hf_idle_a: assert property ((!hf_osc_en && !$past(hf_osc_en)) |-> hf_clk_out)
    else $error("disabled fast clock not high");
  lf_idle_a: assert property ((!lf_osc_en && !$past(lf_osc_en)) |-> lf_clk_out)
    else $error("disabled slow clock not high");
  osc_rst_a: assert property ($past(srst) |-> (hf_osc_en && !lf_osc_en))
    else $error("wrong oscillator enables after reset");
  cpu_gate_a: assert property ((core_rst_out && $past(core_rst_out)) |-> !cpu_tick)
    else $error("processor clock ran during reset");
  rd_idle_a: assert property (!$past(reg_rd) |-> (reg_rdata == 8'h00))
    else $error("read data outside read cycle");
  irq_gate_a: assert property (irq_out |-> $past(global_irq_en))
    else $error("interrupt without global enable");
  tick_pulse_a: assert property (cpu_tick |=> !cpu_tick)
    else $error("processor tick too long");
  done_end_a: assert property (mem_done |-> (!mem_busy && $past(cpu_tick)))
    else $error("access ended off a tick");
  mem_c: cover property (mem_done && $past(mem_reg_ram));
  irq_c: cover property ($rose(irq_out));
  rst_c: cover property ($fell(core_rst_out));
endmodule

// [bench/crt_top_tb_top.sv]
// Testbench for the clock, reset and timer unit
`timescale 1ns/1ps
module crt_top_tb_top;
  localparam RST_HOLD_CYCLES = 20;
  localparam LIM = 600;
  reg        clk = 0, srst = 1, reset_pin_n = 1, hf_osc_in = 0, lf_osc_in = 0;
  reg        mem_req = 0, mem_reg_ram = 0, reg_wr = 0, reg_rd = 0, global_irq_en = 0;
  reg  [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, v;
  reg  [4:0] osc_cnt = 5'h00;
  wire [7:0] reg_rdata;
  wire       core_rst_out, hf_osc_en, lf_osc_en, hf_clk_out, lf_clk_out;
  wire       cpu_clk_out, cpu_tick, mem_busy, mem_done, irq_out;
  integer    failures = 0, checks_done = 0, n, i;
  crt_top #(.RST_HOLD_CYCLES(RST_HOLD_CYCLES)) dut (
    .clk(clk), .srst(srst), .reset_pin_n(reset_pin_n), .core_rst_out(core_rst_out),
    .hf_osc_in(hf_osc_in), .lf_osc_in(lf_osc_in), .hf_osc_en(hf_osc_en), .lf_osc_en(lf_osc_en),
    .hf_clk_out(hf_clk_out), .lf_clk_out(lf_clk_out), .cpu_clk_out(cpu_clk_out), .cpu_tick(cpu_tick),
    .mem_req(mem_req), .mem_reg_ram(mem_reg_ram), .mem_busy(mem_busy), .mem_done(mem_done),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .global_irq_en(global_irq_en), .irq_out(irq_out)
  );
  always #25 clk = ~clk;
  // Fast source period 8 cycles, slow source 32
  always @(posedge clk) begin
    osc_cnt <= osc_cnt + 5'h01;
    hf_osc_in <= osc_cnt[2];
    lf_osc_in <= osc_cnt[4];
  end
  task results;
    begin
      $display("Checks %0d, failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task tmo;
    begin
      failures = failures + 1;
      results;
    end
  endtask
  task chk(input [7:0] s, input [7:0] e);
    begin
      checks_done = checks_done + 1;
      if (s !== e) begin
        failures = failures + 1;
        $display("Error at %0t: seen %h expected %h", $time, s, e);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      v = reg_rdata;
    end
  endtask
  task wt;
    begin
      n = 0;
      @(posedge clk);
      #1;
      while (cpu_tick !== 1'b1 && n < LIM) begin
        @(posedge clk);
        #1;
        n = n + 1;
      end
      if (n >= LIM) tmo;
    end
  endtask
  task gap;
    begin
      wt;
      wt;
      wt;
    end
  endtask
  task rel;
    begin
      n = 0;
      while (core_rst_out !== 1'b0 && n < LIM) begin
        @(posedge clk);
        #1;
        n = n + 1;
      end
      if (n >= LIM) tmo;
    end
  endtask
  task t_reset;
    begin
      #1;
      chk({hf_osc_en, lf_osc_en, lf_clk_out}, 8'h05);
      rel;
      chk(n >= RST_HOLD_CYCLES - 1 && n <= RST_HOLD_CYCLES + 3, 8'h01);
      rd(8'he8);
      chk(v, 8'h01);
    end
  endtask
  task t_regs;
    begin
      wr(8'hea, 8'h5a);
      wr(8'hec, 8'ha5);
      rd(8'hea);
      chk(v, 8'h5a);
      rd(8'hec);
      chk(v, 8'ha5);
      wr(8'he9, 8'hff);
      rd(8'he9);
      chk(v, 8'h07);
      wr(8'h00, 8'h33);
      rd(8'h00);
      chk(v, 8'h00);
      rd(8'hea);
      chk(v, 8'h5a);
    end
  endtask
  task t_div;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        wr(8'he8, 8'h03 | (i << 3));
        gap;
        chk(n + 1, 8 << i);
      end
      wr(8'he8, 8'h07);
      gap;
      chk(n + 1, 32);
      wr(8'he8, 8'h03);
    end
  endtask
  task mem(input [2:0] w, input ram, input [7:0] e);
    begin
      wr(8'he9, {5'h00, w});
      @(posedge clk);
      mem_req <= 1'b1;
      mem_reg_ram <= ram;
      @(posedge clk);
      mem_req <= 1'b0;
      n = 0;
      i = 0;
      #1;
      chk(mem_busy, 8'h01);
      while (mem_done !== 1'b1 && i < LIM) begin
        if (cpu_tick === 1'b1) n = n + 1;
        @(posedge clk);
        #1;
        i = i + 1;
      end
      if (i >= LIM) tmo;
      chk(n, e);
      chk(mem_busy, 8'h00);
    end
  endtask
  task t_timer;
    begin
      wr(8'hea, 8'hfa);
      wr(8'heb, 8'h12);
      rd(8'heb);
      chk(v == 8'hfa || v == 8'hfb, 8'h01);
      wr(8'he7, 8'h00);
      i = 0;
      v = 8'h00;
      while (v[0] !== 1'b1 && i < LIM) begin
        rd(8'hfe);
        i = i + 1;
      end
      if (i >= LIM) tmo;
      chk(irq_out, 8'h00);
      wr(8'he7, 8'h01);
      rd(8'he7);
      chk(v, 8'h01);
      chk(irq_out, 8'h01);
      @(posedge clk);
      global_irq_en <= 1'b0;
      repeat (3) @(posedge clk);
      global_irq_en <= 1'b1;
      #1;
      chk(irq_out, 8'h00);
      for (i = 0; i < 40; i = i + 1) begin
        rd(8'heb);
        chk(v >= 8'hfa, 8'h01);
      end
      wr(8'hea, 8'h00);
      wr(8'heb, 8'h00);
      wr(8'hfe, 8'hfe);
      rd(8'hfe);
      chk(v[0], 8'h00);
      wr(8'hfe, 8'hff);
      rd(8'hfe);
      chk(v[0], 8'h00);
      chk(irq_out, 8'h00);
      wr(8'hfe, 8'hfd);
      wr(8'hec, 8'hfe);
      wr(8'hed, 8'h00);
      i = 0;
      v = 8'h00;
      while (v[1] !== 1'b1 && i < LIM) begin
        rd(8'hfe);
        i = i + 1;
      end
      if (i >= LIM) tmo;
      chk(v[1], 8'h01);
    end
  endtask
  task t_stat;
    begin
      wr(8'he8, 8'h06);
      repeat (8) @(posedge clk);
      #1;
      chk({hf_clk_out, core_rst_out}, 8'h02);
      // Stop the processor clock: slow source selected and disabled
      wr(8'he8, 8'h04);
      repeat (4) @(posedge clk);
      n = 0;
      for (i = 0; i < 40; i = i + 1) begin
        @(posedge clk);
        #1;
        if (cpu_tick === 1'b1) n = n + 1;
      end
      chk(n, 8'h00);
      chk({cpu_clk_out, lf_clk_out, core_rst_out}, 8'h06);
      rd(8'hec);
      chk(v, 8'hfe);
      wr(8'he8, 8'h03);
      gap;
      chk(n + 1, 8'h08);
    end
  endtask
  task t_pin;
    begin
      @(posedge clk);
      reset_pin_n <= 1'b0;
      repeat (5) @(posedge clk);
      reset_pin_n <= 1'b1;
      #1;
      chk(core_rst_out, 8'h01);
      rel;
      chk(n >= RST_HOLD_CYCLES && n <= RST_HOLD_CYCLES + 5, 8'h01);
      rd(8'he8);
      chk(v, 8'h01);
    end
  endtask
  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    global_irq_en <= 1'b1;
    t_reset;
    t_regs;
    t_div;
    mem(3'h1, 1'b0, 8'h02);
    mem(3'h7, 1'b0, 8'h08);
    mem(3'h7, 1'b1, 8'h01);
    t_timer;
    t_stat;
    t_pin;
    results;
  end
endmodule
bind crt_top crt_chk #(.RST_HOLD_CYCLES(RST_HOLD_CYCLES)) chk (
  .clk(clk), .srst(srst), .reset_pin_n(reset_pin_n), .core_rst_out(core_rst_out),
  .hf_osc_in(hf_osc_in), .lf_osc_in(lf_osc_in), .hf_osc_en(hf_osc_en), .lf_osc_en(lf_osc_en),
  .hf_clk_out(hf_clk_out), .lf_clk_out(lf_clk_out), .cpu_clk_out(cpu_clk_out), .cpu_tick(cpu_tick),
  .mem_req(mem_req), .mem_reg_ram(mem_reg_ram), .mem_busy(mem_busy), .mem_done(mem_done),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .global_irq_en(global_irq_en), .irq_out(irq_out)
);
